// ==== rtl/run_src_pkg.sv ====
// Package of constants for the run command source selector
package run_src_pkg;
   // Run source selection codes
   localparam logic [7:0] SRC_TERMINAL   = 8'h01;
   localparam logic [7:0] SRC_KEYPAD     = 8'h02;
   // Keypad direction codes
   localparam logic [7:0] KDIR_FORWARD   = 8'h00;
   localparam logic [7:0] KDIR_REVERSE   = 8'h01;
   // Input terminal function codes
   localparam logic [7:0] FN_FORWARD     = 8'h00;
   localparam logic [7:0] FN_REVERSE     = 8'h01;
   localparam logic [7:0] FN_FORCE_KEY   = 8'h33;
   localparam logic [7:0] FN_FORCE_TERM  = 8'h34;
   localparam logic [7:0] FN_MOTOR2      = 8'h08;
   localparam logic [7:0] FN_START3      = 8'h14;
   localparam logic [7:0] FN_STOP3       = 8'h15;
   localparam logic [7:0] FN_DIR3        = 8'h16;
   localparam logic [7:0] FN_NONE        = 8'hff;
   // Output terminal function code for keypad run enabled
   localparam logic [7:0] OFN_KEYPAD_RUN = 8'h3b;
   // Reset values of the terminal assignment
   localparam logic [7:0] RST_TERM1_FN   = FN_FORWARD;
   localparam logic [7:0] RST_TERM2_FN   = FN_REVERSE;
   localparam logic [7:0] RST_OTHER_FN   = FN_NONE;
   localparam int         NUM_TERMINALS  = 7;
endpackage

// ==== rtl/run_command_source_select.sv ====
// Run command source selection: keypad or terminals, force inputs, three-wire
`timescale 1ns/1ps
// Overview of operation
// - Selection 01 takes run commands from terminals, forward/reverse or three-wire.
// - Selection 02 starts on keypad run key, stops on stop key.
// - When stop-three-wire is assigned, forward/reverse inputs are ignored.
// - Force-keypad or force-terminal inputs override the source selection.
// - Keypad run direction 00 forward, 01 reverse.
// - Output function 59 asserts while the keypad run key may start.
// - Driving starts only with both run command and valid frequency.
// - Forward and reverse both active means stop.
// - Forward alone forward, reverse alone reverse, neither stop.
// - Three-wire: start edge with stop active runs; stop inactive stops.
// - Factory default: terminal 1 forward, terminal 2 reverse.
// - Each terminal carries its assigned function; unassigned functions inactive.
// - Each terminal has its own normally-open or normally-closed polarity, except a three-wire stop terminal, always normally closed.
// - Selection 01 enables sequence program run variables.
// - Second selection copy applies while second-motor input is active.
module run_command_source_select #(
   parameter int N = run_src_pkg::NUM_TERMINALS
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         sys_rst_i,
   // Terminal pins, asynchronous
   input  wire logic [N-1:0] term_pin_i,
   // Keypad keys, asynchronous
   input  wire logic         key_run_i,
   input  wire logic         key_stop_i,
   // Configuration
   input  wire logic         factory_load_i,
   input  wire logic         assign_we_i,
   input  wire logic [2:0]   assign_idx_i,
   input  wire logic [7:0]   assign_fn_i,
   input  wire logic [N-1:0] input_active_polarity_i,
   input  wire logic [7:0]   run_source_select_i,
   input  wire logic [7:0]   run_source_select2_i,
   input  wire logic [7:0]   keypad_run_direction_i,
   input  wire logic [7:0]   output_function_assign_i,
   // Sequence program variables
   input  wire logic         seq_forward_i,
   input  wire logic         seq_reverse_i,
   input  wire logic         seq_start_i,
   input  wire logic         seq_stop_i,
   input  wire logic         seq_dir_i,
   // Frequency command
   input  wire logic         freq_valid_i,
   // Results
   output logic              run_cmd_o,
   output logic              reverse_o,
   output logic              drive_o,
   output logic              seq_enable_o,
   output logic              keypad_src_o,
   output logic              out_terminal_o
);

   // Two-stage synchronisers for pins and keys
   // No reset here: the reset hold of two edges flushes both stages
   logic [N+1:0] sync1;
   logic [N+1:0] sync2;
   always_ff @(posedge ref_clk_i) begin
      sync1 <= {key_stop_i, key_run_i, term_pin_i};
      sync2 <= sync1;
   end

   // Terminal assignment table, in flip-flops; packed so the decode functions
   // can take the whole table as one argument
   logic [N-1:0][7:0] input_function_assign;
   always_ff @(posedge ref_clk_i) begin
      for (int i = 0; i < N; i++) begin
         if (sys_rst_i || factory_load_i) begin
            input_function_assign[i] <= (i == 0) ? run_src_pkg::RST_TERM1_FN :
                                        (i == 1) ? run_src_pkg::RST_TERM2_FN :
                                                   run_src_pkg::RST_OTHER_FN;
         end else if (assign_we_i && (32'(assign_idx_i) == i)) begin
            input_function_assign[i] <= assign_fn_i;
         end
      end
   end

   // Polarity per terminal; three-wire stop is always normally closed
   // A broken stop wire therefore reads as stop, the safe state
   logic [N-1:0] term_level;
   logic [N-1:0] term_raw;
   assign term_raw = sync2[N-1:0];
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (input_function_assign[i] == run_src_pkg::FN_STOP3) begin
            term_level[i] = term_raw[i];
         end else begin
            term_level[i] = term_raw[i] ^ input_active_polarity_i[i];
         end
      end
   end

   // Per-terminal match of one function code; the table travels as an argument
   // so that every decode follows a change of assignment at once
   function automatic logic [N-1:0] fn_match(input logic [N-1:0][7:0] tab,
                                             input logic [7:0]          code);
      logic [N-1:0] m;
      m = '0;
      for (int i = 0; i < N; i++) begin
         m[i] = (tab[i] == code);
      end
      return m;
   endfunction
   // A function is on when any terminal carrying it is at its active level
   function automatic logic fn_active(input logic [N-1:0][7:0] tab,
                                      input logic [N-1:0]      lvl,
                                      input logic [7:0]        code);
      return |(fn_match(tab, code) & lvl);
   endfunction

   // Decoded functions
   wire f_fw    = fn_active(input_function_assign, term_level, run_src_pkg::FN_FORWARD);
   wire f_rv    = fn_active(input_function_assign, term_level, run_src_pkg::FN_REVERSE);
   wire f_sta   = fn_active(input_function_assign, term_level, run_src_pkg::FN_START3);
   wire f_stp   = fn_active(input_function_assign, term_level, run_src_pkg::FN_STOP3);
   wire f_fr    = fn_active(input_function_assign, term_level, run_src_pkg::FN_DIR3);
   wire f_fkey  = fn_active(input_function_assign, term_level, run_src_pkg::FN_FORCE_KEY);
   wire f_fterm = fn_active(input_function_assign, term_level, run_src_pkg::FN_FORCE_TERM);
   wire f_mot2  = fn_active(input_function_assign, term_level, run_src_pkg::FN_MOTOR2);
   wire stp_asg = |fn_match(input_function_assign, run_src_pkg::FN_STOP3);

   // Effective source; force keypad wins if both forces are on
   // Neither force and an unmapped selection gives no source at all
   wire [7:0] sel_code  = f_mot2 ? run_source_select2_i : run_source_select_i;
   wire       src_key   = f_fkey ||
                          (!f_fterm && sel_code == run_src_pkg::SRC_KEYPAD);
   wire       src_term  = !f_fkey &&
                          (f_fterm || sel_code == run_src_pkg::SRC_TERMINAL);
   wire       seq_on    = (sel_code == run_src_pkg::SRC_TERMINAL);

   // Forward/reverse decode, terminal or sequence variables
   // Sequence variables join by OR, so either side can command a run
   wire fw_any  = f_fw || (seq_on && seq_forward_i);
   wire rv_any  = f_rv || (seq_on && seq_reverse_i);
   wire fr_run  = fw_any ^ rv_any;
   wire fr_rev  = rv_any && !fw_any;

   // Three-wire decode; stop uses level, start uses rising edge
   // The edge detector clears low, the idle level of a start push button
   wire sta_any = f_sta || (seq_on && seq_start_i);
   wire stp_any = f_stp || (seq_on && seq_stop_i);
   wire dir_any = f_fr || (seq_on && seq_dir_i);
   logic sta_prev;
   logic tw_run;
   wire  sta_rise = sta_any && !sta_prev;
   wire  three_wire = stp_asg;
   wire  next_tw_run = !stp_any ? 1'b0 :
                       (sta_rise ? 1'b1 : tw_run);

   // Keypad latch: run key starts, stop key stops (stop wins)
   // Latched because both keys are momentary; stop wins for safety
   wire  k_run  = sync2[N];
   wire  k_stop = sync2[N+1];
   logic key_run_lat;
   wire  next_key_run = k_stop ? 1'b0 : (k_run ? 1'b1 : key_run_lat);
   wire  key_rev = (keypad_run_direction_i == run_src_pkg::KDIR_REVERSE);

   // Command selection; the inactive source is not consulted
   // Direction stands even while stopped; only run_cmd_o starts the motor
   wire term_run = three_wire ? tw_run : fr_run;
   wire term_rev = three_wire ? dir_any : fr_rev;
   wire next_run = src_key ? key_run_lat : (src_term ? term_run : 1'b0);
   wire next_rev = src_key ? key_rev : (src_term && term_rev);

   // Three-wire and keypad state; run flags cleared when their source is not chosen, start edge history always tracked
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sta_prev    <= 1'b0;
         tw_run      <= 1'b0;
         key_run_lat <= 1'b0;
      end else begin
         sta_prev    <= sta_any;
         tw_run      <= src_term && three_wire && next_tw_run;
         key_run_lat <= src_key && next_key_run;
      end
   end

   // Registered outputs
   // Registered so no pin glitches while the decode settles
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         run_cmd_o      <= 1'b0;
         reverse_o      <= 1'b0;
         drive_o        <= 1'b0;
         seq_enable_o   <= 1'b0;
         keypad_src_o   <= 1'b0;
         out_terminal_o <= 1'b0;
      end else begin
         run_cmd_o      <= next_run;
         reverse_o      <= next_rev;
         drive_o        <= next_run && freq_valid_i;
         seq_enable_o   <= seq_on;
         keypad_src_o   <= src_key;
         out_terminal_o <= src_key &&
                           (output_function_assign_i == run_src_pkg::OFN_KEYPAD_RUN);
      end
   end

   // Checks
   a_drive_needs_freq: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      drive_o |-> $past(freq_valid_i) && run_cmd_o) else $error("drive without frequency");
   a_both_dir_stop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && !three_wire && fw_any && rv_any) |=> !run_cmd_o)
      else $error("both directions did not stop");
   a_fw_alone_runs: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && !three_wire && fw_any && !rv_any) |=> run_cmd_o && !reverse_o)
      else $error("forward alone did not run forward");
   a_key_dir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_key && key_rev) |=> reverse_o) else $error("keypad direction wrong");
   a_key_ignored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!src_key && !src_term) |=> !run_cmd_o) else $error("run without source");
   a_stop_three: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && three_wire && !stp_any) |=> !tw_run) else $error("three-wire stop lost");
   a_force_key: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      f_fkey |=> keypad_src_o) else $error("force keypad ignored");
   a_out_term: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      out_terminal_o |-> keypad_src_o) else $error("output terminal without keypad source");
   a_seq_enable: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !$past(sys_rst_i) |-> seq_enable_o == $past(sel_code == run_src_pkg::SRC_TERMINAL))
      else $error("sequence enable wrong");

   // Source selection and overrides
   a_term_source: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!f_fkey && !f_fterm && sel_code == run_src_pkg::SRC_TERMINAL) |=> !keypad_src_o)
      else $error("terminal selection not taken");
   a_key_source: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!f_fkey && !f_fterm && sel_code == run_src_pkg::SRC_KEYPAD) |=> keypad_src_o)
      else $error("keypad selection not taken");
   a_force_term: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (f_fterm && !f_fkey) |=> !keypad_src_o)
      else $error("force terminal ignored");
   a_second_copy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (f_mot2 && !f_fkey && !f_fterm &&
       run_source_select2_i == run_src_pkg::SRC_KEYPAD) |=> keypad_src_o)
      else $error("second selection copy ignored");
   a_first_copy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!f_mot2 && !f_fkey && !f_fterm &&
       run_source_select_i == run_src_pkg::SRC_TERMINAL) |=> !keypad_src_o)
      else $error("first selection copy ignored");

   // Forward/reverse and three-wire decode
   a_rv_alone_rev: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && !three_wire && rv_any && !fw_any) |=> run_cmd_o && reverse_o)
      else $error("reverse alone did not run reverse");
   a_neither_stop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && !three_wire && !fw_any && !rv_any) |=> !run_cmd_o)
      else $error("no direction did not stop");
   a_fw_ignored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && three_wire && !tw_run) |=> !run_cmd_o)
      else $error("forward/reverse not ignored in three-wire");
   a_three_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && three_wire && stp_any && sta_rise) |=> tw_run)
      else $error("three-wire start lost");
   a_three_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && three_wire && stp_any && tw_run) |=> tw_run)
      else $error("three-wire run dropped");
   a_three_dir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_term && three_wire && tw_run && dir_any) |=> run_cmd_o && reverse_o)
      else $error("three-wire direction wrong");

   // Keypad latch and direction
   a_key_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_key && k_run && !k_stop) |=> key_run_lat)
      else $error("keypad run key lost");
   a_key_stop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_key && k_stop) |=> !key_run_lat)
      else $error("keypad stop key lost");
   a_key_fwd: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_key && keypad_run_direction_i == run_src_pkg::KDIR_FORWARD) |=> !reverse_o)
      else $error("keypad forward direction wrong");
   a_term_ignores_key: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !src_key |=> !key_run_lat)
      else $error("keypad latch held off its source");

   // Drive permission, defaults and sequence enable
   a_no_freq_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !freq_valid_i |=> !drive_o)
      else $error("drive without valid frequency");
   a_drive_follows: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (next_run && freq_valid_i) |=> drive_o)
      else $error("drive missing with run and frequency");
   a_no_src_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!src_key && !src_term) |=> !drive_o)
      else $error("drive without source");
   a_factory_map: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      factory_load_i |=> input_function_assign[0] == run_src_pkg::FN_FORWARD &&
                         input_function_assign[1] == run_src_pkg::FN_REVERSE)
      else $error("factory assignment wrong");
   a_out_term_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (src_key && output_function_assign_i == run_src_pkg::OFN_KEYPAD_RUN) |=> out_terminal_o)
      else $error("output terminal missing");
   a_seq_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (sel_code != run_src_pkg::SRC_TERMINAL) |=> !seq_enable_o)
      else $error("sequence enabled off terminal selection");

   // Coverage of the main scenarios
   c_key_run: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      keypad_src_o && run_cmd_o);
   c_three_wire_run: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      three_wire && tw_run);
   c_reverse_drive: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      drive_o && reverse_o);
   c_force_terminal: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      f_fterm && !keypad_src_o);
   c_second_motor: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      f_mot2 && keypad_src_o);

endmodule

// ==== dv/switch_panel.sv ====
// Behavioural model of the keypad keys and the terminal switches
`timescale 1ns/1ps
module switch_panel (
   // Switch states commanded by the bench
   input  wire logic [6:0] sw_on_i,
   input  wire logic [6:0] nc_i,
   input  wire logic       run_press_i,
   input  wire logic       stop_press_i,
   // Pins and keys seen by the block
   output logic [6:0]      term_pin_o,
   output logic            key_run_o,
   output logic            key_stop_o
);
   // A normally-closed contact reads high at rest and opens when operated
   assign term_pin_o = sw_on_i ^ nc_i;
   // Keys are plain momentary contacts, high while pressed
   assign key_run_o  = run_press_i;
   assign key_stop_o = stop_press_i;
endmodule

// ==== dv/tb.sv ====
// Self-checking testbench for the run command source selector
`timescale 1ns/1ps
module tb;
   logic       ref_clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [6:0] sw_on = 7'h00;
   logic [6:0] nc = 7'h00;
   logic       run_key = 1'b0;
   logic       stop_key = 1'b0;
   logic       fload = 1'b0;
   logic       we = 1'b0;
   logic [2:0] idx = 3'h0;
   logic [7:0] fn = 8'hff;
   logic [7:0] src = 8'h01;
   logic [7:0] src2 = 8'h01;
   logic [7:0] kdir = 8'h00;
   logic [7:0] ofn = 8'h3b;
   logic [4:0] seq = 5'h00;
   logic       freq = 1'b1;
   logic [6:0] pins;
   logic       krun;
   logic       kstop;
   logic       run, rev, drv, seqen, ksrc, oterm;
   wire  [5:0] outs = {run, rev, drv, seqen, ksrc, oterm};
   int         num_errors = 0;
   int         samples_checked = 0;
   // Clock at 125 MHz
   always #4 ref_clk_i = ~ref_clk_i;
   // Far-side switches and keys
   switch_panel PNL (.sw_on_i(sw_on), .nc_i(nc), .run_press_i(run_key),
      .stop_press_i(stop_key), .term_pin_o(pins), .key_run_o(krun), .key_stop_o(kstop));
   // Block under test
   run_command_source_select DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .term_pin_i(pins), .key_run_i(krun), .key_stop_i(kstop), .factory_load_i(fload),
      .assign_we_i(we), .assign_idx_i(idx), .assign_fn_i(fn), .input_active_polarity_i(nc),
      .run_source_select_i(src), .run_source_select2_i(src2),
      .keypad_run_direction_i(kdir), .output_function_assign_i(ofn),
      .seq_forward_i(seq[4]), .seq_reverse_i(seq[3]), .seq_start_i(seq[2]),
      .seq_stop_i(seq[1]), .seq_dir_i(seq[0]), .freq_valid_i(freq), .run_cmd_o(run),
      .reverse_o(rev), .drive_o(drv), .seq_enable_o(seqen), .keypad_src_o(ksrc),
      .out_terminal_o(oterm));
   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [5:0] seen, input logic [5:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Inputs only move just after a falling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic asg(input logic [2:0] i, input logic [7:0] f);
      idx = i;
      fn = f;
      we = 1'b1;
      cyc(1);
      we = 1'b0;
      cyc(1);
   endtask
   task automatic press(input logic stop);
      run_key = ~stop;
      stop_key = stop;
      cyc(2);
      run_key = 1'b0;
      stop_key = 1'b0;
      cyc(6);
   endtask
   // Forward/reverse truth table, with idle unassigned terminals held on
   task automatic fw_rv_table();
      logic [5:0] exp [4] = '{6'b000100, 6'b101100, 6'b111100, 6'b000100};
      for (int i = 0; i < 4; i++) begin
         sw_on = {5'h1f, i[1:0]};
         cyc(5);
         check(outs, exp[i]);
      end
      sw_on = 7'h01;
      freq = 1'b0;
      cyc(5);
      check(outs, 6'b100100);
      freq = 1'b1;
      nc = 7'h01;
      sw_on = 7'h00;
      cyc(5);
      check(outs, 6'b000100);
      sw_on = 7'h01;
      cyc(5);
      check(outs, 6'b101100);
      nc = 7'h00;
   endtask
   // Keypad source: both directions, stop key, terminals ignored
   task automatic keypad_mode();
      src = 8'h02;
      sw_on = 7'h01;
      cyc(5);
      check(outs, 6'b000011);
      for (int d = 0; d < 2; d++) begin
         kdir = 8'(d);
         press(1'b0);
         check(outs, {1'b1, d[0], 4'b1011});
         press(1'b1);
         check(outs, {1'b0, d[0], 4'b0011});
      end
      kdir = 8'h00;
      ofn = 8'h00;
      cyc(2);
      check(outs, 6'b000010);
      ofn = 8'h3b;
   endtask
   // Force inputs and the second selection copy override the selection
   task automatic overrides();
      asg(3'h2, 8'h33);
      src = 8'h01;
      sw_on = 7'h04;
      cyc(5);
      check({5'h00, ksrc}, 6'h01);
      asg(3'h2, 8'h34);
      src = 8'h02;
      cyc(5);
      check({5'h00, ksrc}, 6'h00);
      asg(3'h2, 8'hff);
      asg(3'h3, 8'h08);
      src = 8'h01;
      src2 = 8'h02;
      sw_on = 7'h08;
      cyc(5);
      check({5'h00, ksrc}, 6'h01);
      sw_on = 7'h00;
      seq = 5'h10;
      cyc(5);
      check(outs, 6'b101100);
      src = 8'h02;
      cyc(3);
      check(outs, 6'b000011);
      src = 8'h03;
      cyc(3);
      check(outs, 6'b000000);
      seq = 5'h00;
      src = 8'h01;
   endtask
   // Three-wire start, direction and stop, forward input ignored
   task automatic three_wire();
      asg(3'h4, 8'h14);
      asg(3'h5, 8'h15);
      asg(3'h6, 8'h16);
      sw_on = 7'h21;
      cyc(5);
      check(outs, 6'b000100);
      sw_on = 7'h31;
      cyc(3);
      sw_on = 7'h21;
      cyc(5);
      check(outs, 6'b101100);
      sw_on = 7'h61;
      cyc(5);
      check(outs, 6'b111100);
      sw_on = 7'h41;
      cyc(5);
      check(outs, 6'b010100);
   endtask
   // Main sequence
   initial begin
      cyc(2);
      sys_rst_i = 1'b0;
      fload = 1'b1;
      cyc(1);
      fload = 1'b0;
      fw_rv_table();
      keypad_mode();
      overrides();
      three_wire();
      stop_test();
   end
   // Watchdog well beyond the 140 or so cycles the tests need
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      num_errors++;
      stop_test();
   end
endmodule
